// File: fwkl_top.sv
// fwkl_top: key sequence guard for in-system flash writes and erasures.
// assumes a core on clk_in issuing one-cycle register and flash strobes.
`timescale 1ns/1ps
`default_nettype none
module fwkl_top
	import fwkl_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [1:0]  size_sel_in,
	// special-function register port
	input  wire logic        sfr_wr_in,
	input  wire logic        sfr_rd_in,
	input  wire logic [7:0]  sfr_addr_in,
	input  wire logic [7:0]  sfr_wdata_in,
	output logic [7:0]       sfr_rdata_out,
	output logic             sfr_hit_out,
	// flash operations from the core
	input  wire logic        code_rd_in,
	input  wire logic        data_wr_in,
	input  wire logic        flash_sel_in,
	input  wire logic        erase_in,
	input  wire logic [15:0] prog_addr_in,
	input  wire logic [7:0]  prog_wdata_in,
	input  wire logic        flash_done_in,
	// towards the flash array
	output logic             flash_rd_out,
	output logic             flash_wr_out,
	output logic             flash_erase_out,
	output logic [15:0]      flash_addr_out,
	output logic [7:0]       flash_wdata_out,
	output logic             flash_busy_out,
	output logic             reserved_hit_out,
	output logic             lock_byte_hit_out,
	output logic [1:0]       lock_state_out
);

	////////////////////////////////////////////////////////////////////////
	// reset release: asynchronous assert, two-stage synchronous release

	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	////////////////////////////////////////////////////////////////////////
	// address classification

	logic        in_flash;
	logic        is_lock;
	logic        reserved;

	fwkl_addr_map u_map (
		.size_sel_in      (size_sel_in),
		.addr_in          (prog_addr_in),
		.in_flash_out     (in_flash),
		.is_lock_byte_out (is_lock),
		.reserved_out     (reserved),
		.lock_addr_out    ()
	);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		fwkl_state_e state;
		logic        busy;
		logic        rd;
		logic        wr;
		logic        erase;
		logic        res_hit;
		logic        lock_hit;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
	} fwkl_regs_s;

	// reset image: locked, no op in flight, read data zero
	localparam fwkl_regs_s FWKL_REGS_RESET = '{
		state:    FWKL_LOCKED,
		busy:     1'b0,
		rd:       1'b0,
		wr:       1'b0,
		erase:    1'b0,
		res_hit:  1'b0,
		lock_hit: 1'b0,
		addr:     16'h0000,
		wdata:    8'h00,
		rdata:    FWKL_KEY_RESET
	};

	fwkl_regs_s st_reg;
	fwkl_regs_s st_next;

	logic key_wr;
	logic key_rd;
	logic op_req;

	// key register decode; other special-function addresses are not ours
	assign key_wr = sfr_wr_in && (sfr_addr_in == FWKL_KEY_ADDR);
	assign key_rd = sfr_rd_in && (sfr_addr_in == FWKL_KEY_ADDR);
	// a data write only reaches flash while redirected
	assign op_req = data_wr_in && flash_sel_in;

	////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		st_next          = st_reg;
		st_next.rd       = 1'b0;
		st_next.wr       = 1'b0;
		st_next.erase    = 1'b0;
		st_next.res_hit  = 1'b0;
		st_next.lock_hit = 1'b0;

		// code reads within flash always go to flash, never gated by the key
		if (code_rd_in) begin
			st_next.rd       = in_flash;
			st_next.addr     = prog_addr_in;
			st_next.res_hit  = reserved;
			st_next.lock_hit = is_lock;
		end

		// key register writes walk the sequence
		if (key_wr) begin
			unique case (st_reg.state)
				FWKL_LOCKED: begin
					// any value but the first key locks out
					st_next.state = (sfr_wdata_in == FWKL_KEY_FIRST) ?
						FWKL_KEY1 : FWKL_LOCKOUT;
				end
				FWKL_KEY1: begin
					st_next.state = (sfr_wdata_in == FWKL_KEY_SECOND) ?
						FWKL_OPEN : FWKL_LOCKOUT;
				end
				FWKL_OPEN: begin
					// a key write while already open is out of sequence
					st_next.state = FWKL_LOCKOUT;
				end
				FWKL_LOCKOUT: begin
					st_next.state = FWKL_LOCKOUT;
				end
			endcase
		end else if (op_req) begin
			// write or erase: only one per key pair, none while busy
			if (st_reg.state == FWKL_OPEN && !st_reg.busy) begin
				st_next.busy     = 1'b1;
				st_next.wr       = !erase_in;
				st_next.erase    = erase_in;
				st_next.addr     = prog_addr_in;
				st_next.wdata    = prog_wdata_in;
				st_next.res_hit  = reserved;
				st_next.lock_hit = is_lock;
			end else if (!st_reg.busy) begin
				st_next.state = FWKL_LOCKOUT;
			end
		end

		// completion withdraws permission; lockout is never left
		// a key write in the completion cycle has already moved to lockout,
		// so only a still-open state drops back to locked
		if (st_reg.busy && flash_done_in) begin
			st_next.busy = 1'b0;
			if (st_next.state == FWKL_OPEN) begin
				st_next.state = FWKL_LOCKED;
			end
		end

		// read data: state in low bits, upper bits zero
		if (key_rd) begin
			st_next.rdata = {6'h00, st_reg.state};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= FWKL_REGS_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// every output but the hit flag is a register, so the core sees no glitch
	assign sfr_hit_out       = key_wr || key_rd;
	assign sfr_rdata_out     = st_reg.rdata;
	assign flash_rd_out      = st_reg.rd;
	assign flash_wr_out      = st_reg.wr;
	assign flash_erase_out   = st_reg.erase;
	assign flash_addr_out    = st_reg.addr;
	assign flash_wdata_out   = st_reg.wdata;
	assign flash_busy_out    = st_reg.busy;
	assign reserved_hit_out  = st_reg.res_hit;
	assign lock_byte_hit_out = st_reg.lock_hit;
	assign lock_state_out    = st_reg.state;

endmodule
`default_nettype wire

// File: fwkl_pkg.sv
// fwkl_pkg: constants and types shared by the flash write key lock block.
// assumes nothing of its surroundings; imported whole by every module but the flash model.
package fwkl_pkg;

	// special-function address of the key register
	localparam logic [7:0]  FWKL_KEY_ADDR     = 8'hb7;
	localparam logic [7:0]  FWKL_KEY_RESET    = 8'h00;
	// ordered key pair
	localparam logic [7:0]  FWKL_KEY_FIRST    = 8'ha5;
	localparam logic [7:0]  FWKL_KEY_SECOND   = 8'hf1;
	// program space and flash sizes in bytes
	localparam logic [16:0] FWKL_SPACE_BYTES  = 17'h10000;
	localparam logic [16:0] FWKL_FLASH_8K     = 17'h02000;
	localparam logic [16:0] FWKL_FLASH_4K     = 17'h01000;
	localparam logic [16:0] FWKL_FLASH_2K     = 17'h00800;
	// lock state field position in the key register
	localparam int          FWKL_STATE_LSB    = 0;
	localparam int          FWKL_STATE_W      = 2;
	// flash size select encoding
	localparam logic [1:0]  FWKL_SIZE_8K      = 2'h0;
	localparam logic [1:0]  FWKL_SIZE_4K      = 2'h1;
	localparam logic [1:0]  FWKL_SIZE_2K      = 2'h2;

	// lock states; the codes are the values read back in bits 1-0
	typedef enum logic [1:0] {
		FWKL_LOCKED   = 2'h0,
		FWKL_KEY1     = 2'h1,
		FWKL_OPEN     = 2'h2,
		FWKL_LOCKOUT  = 2'h3
	} fwkl_state_e;

endpackage

// File: fwkl_addr_map.sv
// fwkl_addr_map: classifies a program-space address against flash size.
// assumes a 16-bit program address from the core, same clock domain.
`timescale 1ns/1ps
`default_nettype none
module fwkl_addr_map
	import fwkl_pkg::*;
(
	input  wire logic [1:0]  size_sel_in,
	input  wire logic [15:0] addr_in,
	output logic             in_flash_out,
	output logic             is_lock_byte_out,
	output logic             reserved_out,
	output logic [15:0]      lock_addr_out
);

	logic [16:0] flash_bytes;

	// flash size per variant; an unused code falls back to the smallest
	always_comb begin
		unique case (size_sel_in)
			FWKL_SIZE_8K: flash_bytes = FWKL_FLASH_8K;
			FWKL_SIZE_4K: flash_bytes = FWKL_FLASH_4K;
			default:      flash_bytes = FWKL_FLASH_2K;
		endcase
	end

	// last flash byte is the security lock byte; above it is reserved
	assign lock_addr_out    = 16'(flash_bytes - 17'h00001);
	assign in_flash_out     = {1'b0, addr_in} < flash_bytes;
	assign is_lock_byte_out = addr_in == lock_addr_out;
	assign reserved_out     = !in_flash_out;

endmodule
`default_nettype wire

// File: fwkl_chk.sv
// fwkl_chk: timing checks on the key guard pins
// assumes binding to fwkl_top, one clock
`timescale 1ns/1ps
`default_nettype none
module fwkl_chk
	import fwkl_pkg::*;
(
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic       sfr_wr_in,
	input wire logic       sfr_rd_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic       data_wr_in,
	input wire logic       flash_sel_in,
	input wire logic       flash_done_in,
	input wire logic       flash_wr_out,
	input wire logic       flash_erase_out,
	input wire logic       flash_busy_out,
	input wire logic [1:0] lock_state_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////////////////////////
	// key write, legal next key, accepted flash op
	wire logic [1:0] s = lock_state_out;
	wire logic k = sfr_wr_in && sfr_addr_in == FWKL_KEY_ADDR;
	wire logic g = s == 2'h0 && sfr_wdata_in == FWKL_KEY_FIRST
		|| s == 2'h1 && sfr_wdata_in == FWKL_KEY_SECOND;
	wire logic o = data_wr_in && flash_sel_in && !flash_busy_out && !k;
	wire logic f = flash_wr_out || flash_erase_out;
	sequence s_go; s == 2'h2 && o; endsequence
	sequence s_run; f && flash_busy_out; endsequence
	key_step_a: assert property (k && g |=> s == $past(s) + 2'h1)
		else $error("key step");
	bad_key_a: assert property (k && !g |=> s == 2'h3)
		else $error("bad key kept");
	op_issue_a: assert property (s_go |=> s_run)
		else $error("op not issued");
	op_gate_a: assert property (f |-> $past(s) == 2'h2)
		else $error("op while locked");
	relock_a: assert property (flash_busy_out && flash_done_in && s == 2'h2
		|=> !flash_busy_out && s == 2'h0) else $error("no relock");
	locked_op_a: assert property (o && s != 2'h2 |=> s == 2'h3)
		else $error("no lockout");
	lockout_hold_a: assert property (s == 2'h3 |=> s == 2'h3)
		else $error("lockout left");
	key_read_a: assert property (sfr_rd_in && sfr_addr_in == FWKL_KEY_ADDR
		|=> sfr_rdata_out == {6'h00, $past(s)}) else $error("read");
endmodule
`default_nettype wire

// File: fwkl_flash_model.sv
// fwkl_flash_model: flash array answering each op with one done pulse
// assumes one-cycle issue pulses and dly_in of at least 1
`timescale 1ns/1ps
`default_nettype none
module fwkl_flash_model (
	input  wire logic       clk_in,
	input  wire logic       go_in,
	input  wire logic [3:0] dly_in,
	output logic            done_out
);
	logic [3:0] cnt_reg = 4'h0;
	// busy time is set per op so slow flash can be tried too
	always_ff @(posedge clk_in) begin
		done_out <= cnt_reg == 4'h1;
		if (go_in) begin
			cnt_reg <= dly_in;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end
endmodule
`default_nettype wire

// File: tb.sv
// tb: core-side driver and checks for the key guard
// assumes design, checker and flash model in one folder
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fwkl_pkg::*;
	logic        clk_in = 1'h0, rst_n_in = 1'h0, wr = 1'h0, rd = 1'h0;
	logic        cs = 1'h0, dw = 1'h0, sel = 1'h0, er = 1'h0;
	logic        done, fw, fe, bz, fr, rv, lb, hit;
	logic [1:0]  sz = 2'h0, st;
	logic [7:0]  a = 8'h00, wd = 8'h00, rq, fwd;
	logic [15:0] pa = 16'h0000, fa;
	logic [3:0]  dl = 4'h1;
	int          fails = 0, n_checks = 0;
	always #2 clk_in = ~clk_in;
	fwkl_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .size_sel_in(sz),
		.sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_addr_in(a), .sfr_wdata_in(wd),
		.sfr_rdata_out(rq), .sfr_hit_out(hit), .code_rd_in(cs), .data_wr_in(dw),
		.flash_sel_in(sel), .erase_in(er), .prog_addr_in(pa),
		.prog_wdata_in(8'h3c), .flash_done_in(done), .flash_rd_out(fr),
		.flash_wr_out(fw), .flash_erase_out(fe), .flash_addr_out(fa),
		.flash_wdata_out(fwd), .flash_busy_out(bz), .reserved_hit_out(rv),
		.lock_byte_hit_out(lb), .lock_state_out(st));
	fwkl_flash_model fm (.clk_in(clk_in), .go_in(fw | fe), .dly_in(dl),
		.done_out(done));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] g, e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// each strobe starts a fresh cycle so no signal is set twice at once
	task automatic kw(input logic [7:0] v);
		@(negedge clk_in) a = FWKL_KEY_ADDR;
		wd = v;
		wr = 1'h1;
		@(negedge clk_in) wr = 1'h0;
	endtask
	task automatic rk(input logic [1:0] e);
		@(negedge clk_in) a = FWKL_KEY_ADDR;
		rd = 1'h1;
		@(posedge clk_in) chk(hit, 16'h0001);
		@(negedge clk_in) rd = 1'h0;
		chk({8'h00, rq}, {14'h0000, e});
	endtask
	task automatic op(input logic s, e, input logic [15:0] v);
		@(negedge clk_in) pa = v;
		sel = s;
		er = e;
		dw = 1'h1;
		@(negedge clk_in) dw = 1'h0;
	endtask
	task automatic cr(input logic [15:0] v);
		@(negedge clk_in) pa = v;
		cs = 1'h1;
		@(posedge clk_in) chk(hit, 16'h0000);
		@(negedge clk_in) cs = 1'h0;
	endtask
	task automatic rst;
		rst_n_in = 1'h0;
		repeat (8) @(negedge clk_in);
		rst_n_in = 1'h1;
		repeat (3) @(negedge clk_in);
	endtask
	task automatic results;
		if (fails == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		#20000;
		fails++;
		results();
	end
	initial begin
		rst();
		rk(2'h0);
		op(1'h0, 1'h0, 16'h0010);
		chk({fw, st}, 3'h0);
		// a byte write on prompt flash, then an erase on slow flash
		for (int i = 0; i < 2; i++) begin
			dl = i[0] ? 4'h6 : 4'h1;
			kw(FWKL_KEY_FIRST);
			rk(2'h1);
			kw(FWKL_KEY_SECOND);
			rk(2'h2);
			op(1'h1, i[0], 16'h0123);
			chk({fw, fe, bz}, {~i[0], i[0], 1'h1});
			chk(fa, 16'h0123);
			chk(fwd, 16'h003c);
			repeat (20) if (bz) @(negedge clk_in);
			rk(2'h0);
		end
		// three ways into lockout (op while locked, bad second key, bad first key); keys and ops then stay refused
		for (int j = 0; j < 3; j++) begin
			if (j == 0) op(1'h1, 1'h0, 16'h0010);
			if (j == 1) kw(FWKL_KEY_FIRST);
			if (j == 1) kw(8'h00);
			if (j == 2) kw(8'h5a);
			rk(2'h3);
			kw(FWKL_KEY_FIRST);
			kw(FWKL_KEY_SECOND);
			op(1'h1, 1'h0, 16'h0010);
			chk({fw, st}, 3'h3);
			rst();
			rk(2'h0);
		end
		// lock byte and first reserved address per size code; 3 acts as 2 kB
		for (int s = 0; s < 4; s++) begin
			sz = s[1:0];
			cr(16'h0000);
			chk({fr, rv}, 2'h2);
			cr((16'h2000 >> (s > 2 ? 2 : s)) - 16'h0001);
			chk({fr, lb, rv}, 3'h6);
			cr(16'h2000 >> (s > 2 ? 2 : s));
			chk({fr, lb, rv}, 3'h1);
		end
		results();
	end
endmodule
bind fwkl_top fwkl_chk chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_addr_in(sfr_addr_in),
	.sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
	.data_wr_in(data_wr_in), .flash_sel_in(flash_sel_in),
	.flash_done_in(flash_done_in), .flash_wr_out(flash_wr_out),
	.flash_erase_out(flash_erase_out), .flash_busy_out(flash_busy_out),
	.lock_state_out(lock_state_out));
`default_nettype wire
